/* common/prpr_defines.svh */
// Constants for the remote packet responder
`ifndef PRPR_DEFINES_SVH
`define PRPR_DEFINES_SVH
`define PRPR_ID_HI         29
`define PRPR_ID_LO         24
`define PRPR_TAG_HI        31
`define PRPR_TAG_LO        30
`define PRPR_RSV_HI        23
`define PRPR_RSV_LO        22
`define PRPR_STAT_HI       7
`define PRPR_STAT_LO       4
`define PRPR_DATA_HI       7
`define PRPR_DATA_LO       0
`define PRPR_TYPE_HI       21
`define PRPR_TYPE_LO       18
`define PRPR_PAGE_HI       17
`define PRPR_PAGE_LO       15
`define PRPR_PORT_HI       14
`define PRPR_PORT_LO       11
`define PRPR_REG_HI        10
`define PRPR_REG_LO        8
`define PRPR_CMND_HI       2
`define PRPR_CMND_LO       0
`define PRPR_OK_BIT        3
`define PRPR_TYPE_PING     4'h0
`define PRPR_TYPE_ACC_BASE 4'h1
`define PRPR_TYPE_RPL_BASE 4'h3
`define PRPR_TYPE_ACC_PAGE 4'h5
`define PRPR_TYPE_RPL_PAGE 4'h7
`define PRPR_TYPE_CMD      4'h8
`define PRPR_TYPE_CONF     4'ha
`define PRPR_TAG_SELFID    2'h2
`define PRPR_TAG_PHY       2'h0
`define PRPR_SELFID_SPEED  2'h2
`define PRPR_PAGE_PORT     3'h0
`define PRPR_PAGE_PROD     3'h1
`define PRPR_PAGED_REG8    3'h0
`define PRPR_PAGED_REG9    3'h1
`define PRPR_PORT_MAX      4'h2
`define PRPR_R8_CONN_BIT   2
`define PRPR_R8_BIAS_BIT   1
`define PRPR_R8_DIS_BIT    0
`define PRPR_R9_FAULT_BIT  3
`define PRPR_CMD_NOP       3'h0
`define PRPR_CMD_DISABLE   3'h1
`define PRPR_CMD_SUSPEND   3'h2
`define PRPR_CMD_CLRFAULT  3'h4
`define PRPR_CMD_ENABLE    3'h5
`define PRPR_CMD_RESUME    3'h6
`endif

/* common/prpr_pkg.sv */
// Types shared by the remote packet responder
package prpr_pkg;
    typedef struct packed {
        logic [31:0] q0;
        logic [31:0] q1;
    } prpr_pkt_s;

    typedef struct packed {
        logic [5:0] gap_cnt;
        logic       contender;
        logic [2:0] pwr;
        logic [1:0] p0;
        logic [1:0] p1;
        logic [1:0] p2;
        logic       init_reset;
    } prpr_selfid_s;

    typedef struct packed {
        logic [2:0] notify;
        logic [2:0] disable_p;
        logic [2:0] suspend;
        logic [2:0] clear_fault;
        logic [2:0] enable;
        logic [2:0] resume;
    } prpr_act_s;

    typedef logic [7:0][7:0] prpr_bank_t;
    typedef logic [2:0][7:0] prpr_port_bank_t;
endpackage

/* hdl/prpr_reg_read.sv */
// Register read selection for remote access replies
`timescale 1ns/1ps
`include "prpr_defines.svh"
module prpr_reg_read
    import prpr_pkg::*;
(
    input  wire logic            paged,
    input  wire logic [2:0]      page,
    input  wire logic [3:0]      port,
    input  wire logic [2:0]      reg_sel,
    input  wire prpr_bank_t      base_regs,
    input  wire prpr_bank_t      prod_regs,
    input  wire prpr_port_bank_t port_r8,
    input  wire prpr_port_bank_t port_r9,
    output logic [7:0]           data
);
    always_comb begin
        data = 8'h00;
        if (!paged) begin
            data = base_regs[reg_sel];
        end else if (port <= `PRPR_PORT_MAX) begin
            if (page == `PRPR_PAGE_PORT) begin
                if (reg_sel == `PRPR_PAGED_REG8) begin
                    data = port_r8[port[1:0]];
                end else if (reg_sel == `PRPR_PAGED_REG9) begin
                    data = port_r9[port[1:0]];
                end
            end else if (page == `PRPR_PAGE_PROD) begin
                data = prod_regs[reg_sel];
            end
        end
    end
endmodule

/* hdl/prpr_cmd_decode.sv */
// Remote command decode and port status lookup
`timescale 1ns/1ps
`include "prpr_defines.svh"
module prpr_cmd_decode
    import prpr_pkg::*;
(
    input  wire logic [3:0]      port,
    input  wire logic [2:0]      cmnd,
    input  wire prpr_port_bank_t port_r8,
    input  wire prpr_port_bank_t port_r9,
    output logic                 ok,
    output logic [3:0]           stat,
    output logic [2:0]           port_sel
);
    logic       port_ok;
    logic       code_ok;
    logic [7:0] r8;
    logic [7:0] r9;

    always_comb begin
        port_ok  = (port <= `PRPR_PORT_MAX);
        r8       = port_ok ? port_r8[port[1:0]] : 8'h00;
        r9       = port_ok ? port_r9[port[1:0]] : 8'h00;
        port_sel = port_ok ? (3'h1 << port[1:0]) : 3'h0;
        // Code 3 and 7 are not defined, so they are refused
        code_ok  = (cmnd != 3'h3) && (cmnd != 3'h7);
        ok       = port_ok && code_ok;
        stat[3]  = r9[`PRPR_R9_FAULT_BIT];
        stat[2]  = r8[`PRPR_R8_CONN_BIT];
        stat[1]  = r8[`PRPR_R8_BIAS_BIT];
        stat[0]  = r8[`PRPR_R8_DIS_BIT];
    end
endmodule

/* hdl/prpr_responder.sv */
// PHY packet responder: ping, remote access and remote command
`timescale 1ns/1ps
`include "prpr_defines.svh"
module prpr_responder
    import prpr_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst_b,
    input  wire logic            in_valid,
    output logic                 in_ready,
    input  wire prpr_pkt_s       in_pkt,
    input  wire logic            in_from_link,
    input  wire logic [5:0]      phy_id,
    input  wire logic            link_active,
    input  wire prpr_selfid_s    selfid_cfg,
    input  wire prpr_bank_t      base_regs,
    input  wire prpr_bank_t      prod_regs,
    input  wire prpr_port_bank_t port_r8,
    input  wire prpr_port_bank_t port_r9,
    output logic                 bus_tx_valid_ff,
    output prpr_pkt_s            bus_tx_pkt_ff,
    output logic                 link_rx_valid_ff,
    output prpr_pkt_s            link_rx_pkt_ff,
    output prpr_act_s            act_ff
);
    typedef enum logic [1:0] {
        S_IDLE,
        S_FWD,
        S_RESP
    } prpr_state_e;

    prpr_state_e state_ff;
    prpr_state_e nxt_state;
    logic [31:0] q0;
    logic [3:0]  ptype;
    logic [3:0]  port;
    logic [2:0]  cmnd;
    logic        take;
    logic        pkt_ok;
    logic        is_ours;
    logic        is_ping;
    logic        is_acc;
    logic        is_paged;
    logic        is_cmd;
    logic        respond;
    logic        fwd;
    logic [7:0]  rd_data;
    logic        cmd_ok;
    logic [3:0]  cmd_stat;
    logic [2:0]  port_sel;
    logic [31:0] selfid_q0;
    logic [31:0] reply_q0;
    logic [31:0] conf_q0;
    logic [31:0] nxt_resp_q0;
    prpr_pkt_s   resp_pkt_ff;
    logic        resp_pend_ff;
    logic [2:0]  dis_pend_ff;
    prpr_act_s   nxt_act;
    logic [7:0]  sel_r8;
    logic [7:0]  sel_r9;
    logic [3:0]  port_stat;
    logic [2:0]  port_hot;

    assign q0       = in_pkt.q0;
    assign ptype    = q0[`PRPR_TYPE_HI:`PRPR_TYPE_LO];
    assign port     = q0[`PRPR_PORT_HI:`PRPR_PORT_LO];
    assign cmnd     = q0[`PRPR_CMND_HI:`PRPR_CMND_LO];
    assign in_ready = (state_ff == S_IDLE);
    // link packets take the same path
    assign take     = in_valid && in_ready;

    // inverse check; a damaged packet is dropped whole
    assign pkt_ok   = (in_pkt.q1 == ~in_pkt.q0);
    // only our own identifier responds
    // R or T set marks a configuration packet, not ours to answer
    assign is_ours  = pkt_ok && (q0[`PRPR_TAG_HI:`PRPR_TAG_LO] == `PRPR_TAG_PHY)
                      && (q0[`PRPR_RSV_HI:`PRPR_RSV_LO] == 2'h0)
                      && (q0[`PRPR_ID_HI:`PRPR_ID_LO] == phy_id);
    assign is_ping  = is_ours && (ptype == `PRPR_TYPE_PING);
    assign is_paged = (ptype == `PRPR_TYPE_ACC_PAGE);
    assign is_acc   = is_ours && ((ptype == `PRPR_TYPE_ACC_BASE) || is_paged);
    assign is_cmd   = is_ours && (ptype == `PRPR_TYPE_CMD);
    assign respond  = is_ping || is_acc || is_cmd;

    // bus packets to link; access echoed too
    assign fwd = pkt_ok && link_active && (!in_from_link || is_acc);

    prpr_reg_read u_reg_read (
        .paged     (is_paged),
        .page      (q0[`PRPR_PAGE_HI:`PRPR_PAGE_LO]),
        .port      (port),
        .reg_sel   (q0[`PRPR_REG_HI:`PRPR_REG_LO]),
        .base_regs (base_regs),
        .prod_regs (prod_regs),
        .port_r8   (port_r8),
        .port_r9   (port_r9),
        .data      (rd_data)
    );

    prpr_cmd_decode u_cmd_decode (
        .port     (port),
        .cmnd     (cmnd),
        .port_r8  (port_r8),
        .port_r9  (port_r9),
        .ok       (cmd_ok),
        .stat     (cmd_stat),
        .port_sel (port_sel)
    );

    assign selfid_q0 = {`PRPR_TAG_SELFID, phy_id, 1'b0, link_active,
                        selfid_cfg.gap_cnt, `PRPR_SELFID_SPEED, 2'h0,
                        selfid_cfg.contender, selfid_cfg.pwr, selfid_cfg.p0,
                        selfid_cfg.p1, selfid_cfg.p2, selfid_cfg.init_reset, 1'b0};

    // reply names this node as source
    assign reply_q0 = {`PRPR_TAG_PHY, phy_id, 2'h0,
                       is_paged ? `PRPR_TYPE_RPL_PAGE : `PRPR_TYPE_RPL_BASE,
                       q0[`PRPR_PAGE_HI:`PRPR_REG_LO], rd_data};

    assign conf_q0 = {`PRPR_TAG_PHY, phy_id, 2'h0, `PRPR_TYPE_CONF, 3'h0, port,
                      3'h0, cmd_stat, cmd_ok, cmnd};

    always_comb begin
        nxt_resp_q0 = conf_q0;
        if (is_ping) begin
            nxt_resp_q0 = selfid_q0;
        end else if (is_acc) begin
            nxt_resp_q0 = reply_q0;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            S_IDLE: begin
                if (take) begin
                    nxt_state = S_FWD;
                end
            end
            S_FWD:  nxt_state = S_RESP;
            S_RESP: nxt_state = S_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= S_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Response goes to the bus at once, no arbitration
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_tx_valid_ff <= 1'b0;
            bus_tx_pkt_ff   <= '0;
            resp_pend_ff    <= 1'b0;
            resp_pkt_ff     <= '0;
        end else if (take) begin
            bus_tx_valid_ff <= respond;
            bus_tx_pkt_ff   <= '{q0: nxt_resp_q0, q1: ~nxt_resp_q0};
            resp_pend_ff    <= respond;
            resp_pkt_ff     <= '{q0: nxt_resp_q0, q1: ~nxt_resp_q0};
        end else begin
            bus_tx_valid_ff <= 1'b0;
            if (state_ff == S_FWD) begin
                resp_pend_ff <= 1'b0;
            end
        end
    end

    // Forwarded packet first, then the local response
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            link_rx_valid_ff <= 1'b0;
            link_rx_pkt_ff   <= '0;
        end else if (take) begin
            link_rx_valid_ff <= fwd;
            link_rx_pkt_ff   <= in_pkt;
        end else if (state_ff == S_FWD) begin
            // self-ID also to link; reply too
            link_rx_valid_ff <= resp_pend_ff;
            link_rx_pkt_ff   <= resp_pkt_ff;
        end else begin
            link_rx_valid_ff <= 1'b0;
        end
    end

    always_comb begin
        nxt_act = '0;
        if (is_cmd && cmd_ok) begin
            unique case (cmnd)
                `PRPR_CMD_DISABLE:  nxt_act.notify      = port_sel;
                `PRPR_CMD_SUSPEND:  nxt_act.suspend     = port_sel;
                `PRPR_CMD_CLRFAULT: nxt_act.clear_fault = port_sel;
                `PRPR_CMD_ENABLE:   nxt_act.enable      = port_sel;
                `PRPR_CMD_RESUME:   nxt_act.resume      = port_sel;
                default:            nxt_act = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            act_ff      <= '0;
            dis_pend_ff <= 3'h0;
        end else if (take) begin
            act_ff      <= nxt_act;
            dis_pend_ff <= nxt_act.notify;
        end else begin
            // Disable only once the notification has gone out
            act_ff           <= '0;
            act_ff.disable_p <= (state_ff == S_FWD) ? dis_pend_ff : 3'h0;
            dis_pend_ff      <= 3'h0;
        end
    end

    // Checker view of the addressed port, rebuilt from the raw banks
    assign sel_r8    = port_r8[port[1:0]];
    assign sel_r9    = port_r9[port[1:0]];
    assign port_stat = {sel_r9[`PRPR_R9_FAULT_BIT], sel_r8[`PRPR_R8_CONN_BIT],
                        sel_r8[`PRPR_R8_BIAS_BIT], sel_r8[`PRPR_R8_DIS_BIT]};
    assign port_hot  = 3'h1 << port[1:0];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_selfid_bus;
        bus_tx_valid_ff && (bus_tx_pkt_ff.q0[31:30] == `PRPR_TAG_SELFID);
    endsequence

    sequence s_selfid_link;
        link_rx_valid_ff && (link_rx_pkt_ff.q0[31:30] == `PRPR_TAG_SELFID);
    endsequence

    sequence s_resp_then_copy;
        bus_tx_valid_ff ##1 (link_rx_valid_ff && (link_rx_pkt_ff == $past(bus_tx_pkt_ff)));
    endsequence

    sequence s_notify_then_disable;
        (act_ff.notify != 3'h0) ##1 (act_ff.disable_p == $past(act_ff.notify));
    endsequence

    a_ping_selfid_out: assert property (
        (take && is_ping) |=> s_selfid_bus ##1 s_selfid_link)
        else $error("ping did not yield self-ID on bus then link");

    a_reply_type_code: assert property (
        (take && is_acc) |=> bus_tx_valid_ff
        && (bus_tx_pkt_ff.q0[`PRPR_TYPE_HI:`PRPR_TYPE_LO]
            == ($past(is_paged) ? `PRPR_TYPE_RPL_PAGE : `PRPR_TYPE_RPL_BASE)))
        else $error("reply type wrong");

    a_reply_source_id: assert property (
        (take && is_acc) |=>
        (bus_tx_pkt_ff.q0[`PRPR_ID_HI:`PRPR_ID_LO] == $past(phy_id)))
        else $error("reply not marked with own identifier");

    a_reply_data_val: assert property (
        (take && is_acc) |=> (bus_tx_pkt_ff.q0[7:0] == $past(rd_data)))
        else $error("reply data differs from addressed register");

    a_tx_inverse_pair: assert property (
        bus_tx_valid_ff |-> (bus_tx_pkt_ff.q1 == ~bus_tx_pkt_ff.q0))
        else $error("second quadlet not inverse of first");

    a_conf_echo_cmd: assert property (
        (take && is_cmd) |=>
        (bus_tx_pkt_ff.q0[`PRPR_TYPE_HI:`PRPR_TYPE_LO] == `PRPR_TYPE_CONF)
        && (bus_tx_pkt_ff.q0[`PRPR_CMND_HI:`PRPR_CMND_LO] == $past(cmnd)))
        else $error("confirmation lacks type A or command echo");

    a_bad_port_nok: assert property (
        (take && is_cmd && (port > `PRPR_PORT_MAX)) |=>
        !bus_tx_pkt_ff.q0[`PRPR_OK_BIT] && (act_ff == '0) ##1 (act_ff == '0))
        else $error("bad port accepted or acted on");

    a_foreign_quiet: assert property (
        (take && !respond) |=> !bus_tx_valid_ff && (act_ff == '0)
        ##1 !link_rx_valid_ff && (act_ff == '0))
        else $error("foreign packet produced a response");

    a_bus_fwd_link: assert property (
        (take && pkt_ok && !in_from_link && link_active) |=>
        link_rx_valid_ff && (link_rx_pkt_ff == $past(in_pkt)))
        else $error("bus packet not forwarded to link");

    a_disable_order: assert property (
        (take && is_cmd && cmd_ok && (cmnd == `PRPR_CMD_DISABLE)) |=>
        s_notify_then_disable)
        else $error("disable not preceded by notification");

    a_resp_link_copy: assert property (
        (take && respond) |=> s_resp_then_copy)
        else $error("response not copied to link after bus");

    a_access_echo_link: assert property (
        (take && is_acc && link_active) |=>
        link_rx_valid_ff && (link_rx_pkt_ff == $past(in_pkt)))
        else $error("access packet not passed to link");

    a_conf_status_bits: assert property (
        (take && is_cmd && (port <= `PRPR_PORT_MAX)) |=>
        (bus_tx_pkt_ff.q0[`PRPR_STAT_HI:`PRPR_STAT_LO] == $past(port_stat)))
        else $error("confirmation status bits differ from port registers");

    a_conf_ok_flag: assert property (
        (take && is_cmd && (port <= `PRPR_PORT_MAX)
         && (cmnd != 3'h3) && (cmnd != 3'h7)) |=> bus_tx_pkt_ff.q0[`PRPR_OK_BIT])
        else $error("accepted command not flagged ok");

    a_bad_page_zero: assert property (
        (take && is_acc && is_paged
         && (q0[`PRPR_PAGE_HI:`PRPR_PAGE_LO] > `PRPR_PAGE_PROD)) |=>
        (bus_tx_pkt_ff.q0[`PRPR_DATA_HI:`PRPR_DATA_LO] == 8'h00))
        else $error("unimplemented page read back nonzero");

    a_bad_port_zero: assert property (
        (take && is_acc && is_paged && (port > `PRPR_PORT_MAX)) |=>
        (bus_tx_pkt_ff.q0[`PRPR_DATA_HI:`PRPR_DATA_LO] == 8'h00))
        else $error("paged read of missing port nonzero");

    a_paged_reg8_read: assert property (
        (take && is_acc && is_paged && (q0[`PRPR_PAGE_HI:`PRPR_PAGE_LO] == `PRPR_PAGE_PORT)
         && (port <= `PRPR_PORT_MAX) && (q0[`PRPR_REG_HI:`PRPR_REG_LO] == `PRPR_PAGED_REG8))
        |=> (bus_tx_pkt_ff.q0[`PRPR_DATA_HI:`PRPR_DATA_LO] == $past(sel_r8)))
        else $error("paged reg 0 did not read register 1000");

    a_suspend_act: assert property (
        (take && is_cmd && (port <= `PRPR_PORT_MAX) && (cmnd == `PRPR_CMD_SUSPEND)) |=>
        (act_ff.suspend == $past(port_hot)))
        else $error("suspend not pulsed on addressed port");

    a_clear_fault_act: assert property (
        (take && is_cmd && (port <= `PRPR_PORT_MAX) && (cmnd == `PRPR_CMD_CLRFAULT)) |=>
        (act_ff.clear_fault == $past(port_hot)))
        else $error("clear fault not pulsed on addressed port");

    a_enable_act: assert property (
        (take && is_cmd && (port <= `PRPR_PORT_MAX) && (cmnd == `PRPR_CMD_ENABLE)) |=>
        (act_ff.enable == $past(port_hot)))
        else $error("enable not pulsed on addressed port");

    a_resume_act: assert property (
        (take && is_cmd && (port <= `PRPR_PORT_MAX) && (cmnd == `PRPR_CMD_RESUME)) |=>
        (act_ff.resume == $past(port_hot)))
        else $error("resume not pulsed on addressed port");
endmodule

/* tb/prpr_far_node.sv */
// Far-side model: packet source plus bus and link sinks
`timescale 1ns/1ps
module prpr_far_node
    import prpr_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      in_ready,
    input  wire logic      bus_tx_valid_ff,
    input  wire prpr_pkt_s bus_tx_pkt_ff,
    input  wire logic      link_rx_valid_ff,
    input  wire prpr_pkt_s link_rx_pkt_ff,
    input  wire prpr_act_s act_ff,
    output logic           in_valid,
    output prpr_pkt_s      in_pkt
);
    int        cyc = 0;
    int        bus_n = 0;
    int        n_cyc;
    int        d_cyc;
    prpr_pkt_s bus_last;
    prpr_pkt_s link_q[$];
    prpr_act_s act_or;

    initial begin
        in_valid = 1'b0;
        in_pkt = '0;
    end

    // Ready seen at the falling edge equals ready just before the next rise
    task automatic send(input prpr_pkt_s p, output int waits);
        logic r;
        @(negedge clk);
        in_valid = 1'b1;
        in_pkt = p;
        for (waits = 0; waits < 10; waits++) begin
            r = in_ready;
            @(posedge clk);
            if (r) break;
            @(negedge clk);
        end
    endtask

    // Released data must not keep looking like the last packet
    task automatic idle();
        @(negedge clk);
        in_valid = 1'b0;
        in_pkt = ~in_pkt;
    endtask

    task automatic clear();
        bus_n = 0;
        link_q.delete();
        act_or = '0;
        n_cyc = -9;
        d_cyc = -9;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (bus_tx_valid_ff) begin
            bus_n <= bus_n + 1;
            bus_last <= bus_tx_pkt_ff;
        end
        if (link_rx_valid_ff) link_q.push_back(link_rx_pkt_ff);
        act_or <= act_or | act_ff;
        if (|act_ff.notify) n_cyc <= cyc;
        if (|act_ff.disable_p) d_cyc <= cyc;
    end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the remote packet responder
`timescale 1ns/1ps
`include "prpr_defines.svh"
module testbench;
    import prpr_pkg::*;
    logic            clk, rst_b, in_valid, in_ready, in_from_link, link_active;
    logic            bus_tx_valid_ff, link_rx_valid_ff;
    logic [5:0]      phy_id;
    prpr_pkt_s       in_pkt, bus_tx_pkt_ff, link_rx_pkt_ff;
    prpr_selfid_s    cfg;
    prpr_bank_t      base_regs, prod_regs;
    prpr_port_bank_t port_r8, port_r9;
    prpr_act_s       act_ff;
    int              n_errors = 0;
    int              checked = 0;
    logic [3:0]      tys [6] = '{4'h0, 4'h1, 4'h5, 4'h8, 4'h3, 4'ha};

    prpr_responder u_prpr_responder (.clk(clk), .rst_b(rst_b), .in_valid(in_valid),
        .in_ready(in_ready), .in_pkt(in_pkt), .in_from_link(in_from_link), .phy_id(phy_id),
        .link_active(link_active), .selfid_cfg(cfg), .base_regs(base_regs),
        .prod_regs(prod_regs), .port_r8(port_r8), .port_r9(port_r9),
        .bus_tx_valid_ff(bus_tx_valid_ff), .bus_tx_pkt_ff(bus_tx_pkt_ff),
        .link_rx_valid_ff(link_rx_valid_ff), .link_rx_pkt_ff(link_rx_pkt_ff), .act_ff(act_ff));

    prpr_far_node u_prpr_far_node (.clk(clk), .in_ready(in_ready),
        .bus_tx_valid_ff(bus_tx_valid_ff), .bus_tx_pkt_ff(bus_tx_pkt_ff),
        .link_rx_valid_ff(link_rx_valid_ff), .link_rx_pkt_ff(link_rx_pkt_ff),
        .act_ff(act_ff), .in_valid(in_valid), .in_pkt(in_pkt));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic stop_test();
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] mk(logic [5:0] id, logic [3:0] t, logic [2:0] pg,
                                       logic [3:0] pt, logic [2:0] rg, logic [2:0] cm);
        return {2'b00, id, 2'b00, t, pg, pt, rg, 5'h00, cm};
    endfunction

    function automatic logic [31:0] q_selfid();
        return {2'b10, phy_id, 1'b0, link_active, cfg.gap_cnt, `PRPR_SELFID_SPEED, 2'b00,
                cfg.contender, cfg.pwr, cfg.p0, cfg.p1, cfg.p2, cfg.init_reset, 1'b0};
    endfunction

    function automatic logic [7:0] rd_data(logic [31:0] q);
        logic [2:0] pg;
        logic [3:0] pt;
        logic [2:0] rg;
        pg = q[17:15];
        pt = q[14:11];
        rg = q[10:8];
        if (q[21:18] == 4'h1) return base_regs[rg];
        if (pt > 4'h2 || pg > 3'h1) return 8'h00;
        if (pg == 3'h1) return prod_regs[rg];
        if (rg == 3'h0) return port_r8[pt[1:0]];
        if (rg == 3'h1) return port_r9[pt[1:0]];
        return 8'h00;
    endfunction

    function automatic logic [31:0] q_conf(logic [31:0] q);
        logic [3:0] pt;
        logic       ok;
        logic [3:0] st;
        pt = q[14:11];
        ok = pt <= 4'h2 && q[1:0] != 2'h3;
        st = pt <= 4'h2 ? {port_r9[pt[1:0]][3], port_r8[pt[1:0]][2:0]} : 4'h0;
        return {2'b00, phy_id, 2'b00, 4'ha, 3'h0, pt, 3'h0, st, ok, q[2:0]};
    endfunction

    task automatic op(input logic [31:0] q, input logic bad);
        prpr_pkt_s  p, r;
        logic       rsp, fwd;
        logic [3:0] t;
        logic [2:0] oh;
        int         w, nx;
        prpr_act_s  ea;
        base_regs = {$urandom, $urandom};
        prod_regs = {$urandom, $urandom};
        port_r8 = prpr_port_bank_t'($urandom);
        port_r9 = prpr_port_bank_t'($urandom);
        cfg = prpr_selfid_s'($urandom);
        p = {q, bad ? q : ~q};
        t = q[21:18];
        rsp = !bad && q[29:24] == phy_id && (t == 4'h0 || t == 4'h1 || t == 4'h5 || t == 4'h8);
        r.q0 = t == 4'h0 ? q_selfid() : t == 4'h8 ? q_conf(q) :
               {2'b00, phy_id, 2'b00, t + 4'h2, q[17:8], rd_data(q)};
        r.q1 = ~r.q0;
        fwd = !bad && link_active && (!in_from_link || (rsp && t[0]));
        oh = 3'b001 << q[12:11];
        ea = '0;
        if (rsp && t == 4'h8 && r.q0[3]) begin
            case (q[2:0])
                3'h1: begin
                    ea.notify = oh;
                    ea.disable_p = oh;
                end
                3'h2: ea.suspend = oh;
                3'h4: ea.clear_fault = oh;
                3'h5: ea.enable = oh;
                3'h6: ea.resume = oh;
                default: ea = '0;
            endcase
        end
        u_prpr_far_node.clear();
        u_prpr_far_node.send(p, w);
        u_prpr_far_node.idle();
        repeat (4) @(negedge clk);
        chk(w < 10, 1'b1);
        if (w >= 10) stop_test();
        nx = int'(fwd) + int'(rsp);
        chk(u_prpr_far_node.bus_n, rsp);
        if (rsp) chk(u_prpr_far_node.bus_last, r);
        chk(u_prpr_far_node.link_q.size(), nx);
        if (fwd) chk(u_prpr_far_node.link_q[0], p);
        if (rsp && nx > 0) chk(u_prpr_far_node.link_q[nx-1], r);
        chk(u_prpr_far_node.act_or, ea);
        if (|ea.notify) chk(u_prpr_far_node.d_cyc - u_prpr_far_node.n_cyc, 1);
    endtask

    initial begin
        int         i, w;
        logic [3:0] pt;
        rst_b = 1'b0;
        in_from_link = 1'b0;
        link_active = 1'b1;
        phy_id = 6'h05;
        cfg = '0;
        base_regs = '0;
        prod_regs = '0;
        port_r8 = '0;
        port_r9 = '0;
        void'($urandom(53));
        repeat (4) @(negedge clk);
        chk({in_ready, bus_tx_valid_ff, link_rx_valid_ff, act_ff}, {1'b1, 20'h0});
        rst_b = 1'b1;
        // Every command code on ports 0..2 and an illegal one
        for (i = 0; i < 32; i++) begin
            pt = i[4:3] == 2'h3 ? 4'hc : {2'h0, i[4:3]};
            in_from_link = i[0];
            link_active = i[1];
            op(mk(phy_id, 4'h8, 3'h0, pt, 3'h0, i[2:0]), 1'b0);
        end
        // Every page, both access types, legal and illegal ports
        for (i = 0; i < 64; i++) begin
            pt = i[4:3] == 2'h3 ? 4'h9 : {2'h0, i[4:3]};
            in_from_link = i[0];
            link_active = 1'b1;
            op(mk(phy_id, i[5] ? 4'h5 : 4'h1, i[2:0], pt, 3'($urandom), 3'h0), 1'b0);
        end
        // Back to back: second offer held off for two cycles
        in_from_link = 1'b0;
        u_prpr_far_node.clear();
        u_prpr_far_node.send({mk(phy_id, 4'h0, 3'h0, 4'h0, 3'h0, 3'h0),
                              ~mk(phy_id, 4'h0, 3'h0, 4'h0, 3'h0, 3'h0)}, w);
        u_prpr_far_node.send({mk(phy_id, 4'h1, 3'h0, 4'h0, 3'h2, 3'h0),
                              ~mk(phy_id, 4'h1, 3'h0, 4'h0, 3'h2, 3'h0)}, w);
        u_prpr_far_node.idle();
        repeat (4) @(negedge clk);
        chk(w, 2);
        chk(u_prpr_far_node.bus_n, 2);
        for (i = 0; i < 300; i++) begin
            if (i % 32 == 0) phy_id = 6'($urandom);
            w = $urandom_range(7);
            in_from_link = w == 0 ? 1'b0 : 1'($urandom_range(1));
            link_active = 1'($urandom_range(1));
            op(mk(w == 0 ? phy_id + 6'h1 : phy_id, tys[$urandom_range(5)], 3'($urandom),
                  4'($urandom_range(4)), 3'($urandom), 3'($urandom)),
               $urandom_range(15) == 0);
        end
        stop_test();
    end
endmodule
